//--- inc/wdt16_pkg.sv
// wdt16_pkg: constants, register map, state types and carriers of the watchdog
// assumes: clk is the cpu clock, registers reached over a plain 16-bit port
// Overview of operation
// - every reset except a bootstrap hardware reset leaves the watchdog enabled
// - sixteen-bit counter, clock divided by 2 or 128
// - after reset count from zero, divide by 2
// - rate select bit chooses divide by 128
// - disable only before first end-init or service
// - counting continues while the cpu idles
// - overflow past maximum triggers internal chip reset
// - watchdog reset drives reset indication low
// - overflow flag set; hardware reset, service clear
// - finish ready-less or ready bus cycle, else abort
// - bootstrap hardware reset leaves watchdog disabled
// - service clears low byte, loads high byte
// - malformed service raises protection fault trap
// - count register is read only
// - control holds reload, rate select, overflow flag
// - control reads 0002h after watchdog reset, else 0000h
package wdt16_pkg;

  // ---------------------------------------------------------------
  // sizes and timing
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W     = 3;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned RLD_W      = 8;
  localparam int unsigned PSC_W      = 7;
  localparam int unsigned SEQ_W      = 10;
  localparam int unsigned INT_W      = 3;
  localparam logic [PSC_W-1:0] DIV_FAST = 7'h02;
  localparam logic [PSC_W-1:0] DIV_SLOW = 7'h00;   // 128 wraps the 7-bit phase
  localparam logic [SEQ_W-1:0] RST_SEQ_CYC = 10'h200; // internal reset sequence
  localparam logic [1:0]       STRAP_WAIT  = 2'h3;    // strap synchroniser fill
  localparam logic [CNT_W-1:0] CNT_MAX     = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_RESET   = 16'h0000;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_COUNT    = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_CONTROL  = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_INT_STAT = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 3'h4;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTL_SEL_BIT   = 0;
  localparam int unsigned CTL_FLAG_BIT  = 1;
  localparam int unsigned CTL_RLD_LSB   = 8;
  localparam int unsigned INT_OVF_BIT   = 0;
  localparam int unsigned INT_FAULT_BIT = 1;
  localparam int unsigned INT_IGN_BIT   = 2;
  localparam int unsigned STS_EN_BIT    = 0;
  localparam int unsigned STS_CLOSE_BIT = 1;
  localparam int unsigned STS_RST_BIT   = 2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    WDT16_RUN   = 2'b00,
    WDT16_DRAIN = 2'b01,
    WDT16_RESET = 2'b10
  } wdt16_fsm_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } wdt16_bus_t;

  typedef struct packed {
    logic service;
    logic serviceFormatOk;
    logic disableReq;
    logic endInit;
    logic softReset;
  } wdt16_cpu_t;

  typedef struct packed {
    logic active;
    logic usesReady;
    logic readyLow;
  } wdt16_xbus_t;

  typedef struct packed {
    logic [PSC_W-1:0] phase;
    logic             tick;
  } wdt16_psc_t;

  typedef struct packed {
    wdt16_fsm_t        fsm;
    logic [CNT_W-1:0]  count;
    logic [RLD_W-1:0]  reload;
    logic              rateSel;
    logic              ovfFlag;
    logic              enabled;
    logic              initClosed;
    logic [1:0]        strapWait;
    logic [1:0]        bootSync;
    logic [SEQ_W-1:0]  seqCnt;
    logic [INT_W-1:0]  intStat;
    logic [INT_W-1:0]  intMask;
    logic [DATA_W-1:0] readData;
    logic              irq;
    logic              chipReset;
    logic              busAbort;
    logic              rstIndN;
    logic              protFault;
  } wdt16_regs_t;

endpackage

//--- rtl/wdt16_prescaler.sv
// wdt16_prescaler: input rate divider of the watchdog counter
// assumes: run and rateSel come from logic on the same clock
`timescale 1ns/1ps
module wdt16_prescaler (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic rateSel,
  output logic      tick
);
  import wdt16_pkg::*;

  wdt16_psc_t psc_ff;
  wdt16_psc_t nxt_psc;

  // -----------------------------------------------------------------
  // divider
  // -----------------------------------------------------------------
  // one-cycle tick every 2 or every 128 cycles
  always_comb begin
    nxt_psc = psc_ff;
    nxt_psc.tick = 1'b0;
    if (!run) begin
      nxt_psc.phase = '0;
    end else begin
      nxt_psc.phase = psc_ff.phase + 7'h01;
      if (rateSel) begin
        nxt_psc.tick = (psc_ff.phase + 7'h01) == DIV_SLOW;
      end else begin
        nxt_psc.tick = psc_ff.phase[0];
        if (psc_ff.phase[0]) begin
          nxt_psc.phase = '0;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      psc_ff <= '0;
    end else begin
      psc_ff <= nxt_psc;
    end
  end

  assign tick = psc_ff.tick;
endmodule

//--- rtl/wdt16_top.sv
// wdt16_top: 16-bit watchdog with reload, rate select and reset control
// assumes: cpu strobes and bus status on clk; bootstrap strap from a pin
`timescale 1ns/1ps
module wdt16_top (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire wdt16_pkg::wdt16_bus_t  bus,
  input  wire wdt16_pkg::wdt16_cpu_t  cpuEv,
  input  wire wdt16_pkg::wdt16_xbus_t xbus,
  input  wire logic               bootstrapPin,
  output logic [wdt16_pkg::DATA_W-1:0] regRdData,
  output logic                    irq,
  output logic                    chipResetReq,
  output logic                    xbusAbort,
  output logic                    resetIndicationOut_n,
  output logic                    protectionFaultTrap
);
  import wdt16_pkg::*;

  wdt16_regs_t      regs_ff;
  wdt16_regs_t      nxt_regs;
  logic             pscTick;
  logic             pscRun;
  logic             strapDone;
  logic [INT_W-1:0] intEv;
  logic [INT_W-1:0] intClr;

  // -----------------------------------------------------------------
  // input rate divider
  // -----------------------------------------------------------------
  // divider runs only while counting is allowed
  assign strapDone = regs_ff.strapWait == STRAP_WAIT;
  assign pscRun    = regs_ff.enabled && strapDone && (regs_ff.fsm == WDT16_RUN);

  wdt16_prescaler u_psc (
    .clk     (clk),
    .rst     (rst),
    .run     (pscRun),
    .rateSel (regs_ff.rateSel),
    .tick    (pscTick)
  );

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    nxt_regs = regs_ff;
    intEv    = '0;
    intClr   = '0;
    nxt_regs.bootSync  = {regs_ff.bootSync[0], bootstrapPin};
    nxt_regs.readData  = '0;
    nxt_regs.busAbort  = 1'b0;
    nxt_regs.protFault = 1'b0;

    // strap capture shortly after reset release
    if (!strapDone) begin
      nxt_regs.strapWait = regs_ff.strapWait + 2'h1;
      if ((regs_ff.strapWait + 2'h1) == STRAP_WAIT && regs_ff.bootSync[1]) begin
        nxt_regs.enabled = 1'b0;
      end
    end

    case (regs_ff.fsm)
      WDT16_RUN: begin
        // end of initialisation closes the disable window
        if (cpuEv.endInit) begin
          nxt_regs.initClosed = 1'b1;
          nxt_regs.rstIndN    = 1'b1;
        end

        // disable only while the window is open
        if (cpuEv.disableReq) begin
          if (!regs_ff.initClosed) begin
            nxt_regs.enabled = 1'b0;
            nxt_regs.count   = CNT_RESET;
          end else begin
            intEv[INT_IGN_BIT] = 1'b1;
          end
        end

        // service versus count, service first
        if (cpuEv.service) begin
          if (cpuEv.serviceFormatOk) begin
            nxt_regs.count      = {regs_ff.reload, 8'h00};
            nxt_regs.ovfFlag    = 1'b0;
            nxt_regs.initClosed = 1'b1;
          end else begin
            nxt_regs.protFault       = 1'b1;
            intEv[INT_FAULT_BIT]     = 1'b1;
          end
        end else if (pscTick && nxt_regs.enabled) begin
          // a disable in this cycle also stops this tick
          if (regs_ff.count == CNT_MAX) begin
            nxt_regs.ovfFlag     = 1'b1;
            intEv[INT_OVF_BIT]   = 1'b1;
            // running bus cycle decides drain or abort
            if (xbus.active && (!xbus.usesReady || xbus.readyLow)) begin
              nxt_regs.fsm = WDT16_DRAIN;
            end else begin
              nxt_regs.busAbort  = xbus.active;
              nxt_regs.fsm       = WDT16_RESET;
              nxt_regs.chipReset = 1'b1;
              nxt_regs.rstIndN   = 1'b0;
              nxt_regs.seqCnt    = '0;
            end
          end else begin
            nxt_regs.count = regs_ff.count + 16'h0001;
          end
        end

        // software reset restarts the watchdog with a clear flag
        if (cpuEv.softReset) begin
          nxt_regs.count      = CNT_RESET;
          nxt_regs.rateSel    = 1'b0;
          nxt_regs.reload     = '0;
          nxt_regs.ovfFlag    = 1'b0;
          nxt_regs.enabled    = 1'b1;
          nxt_regs.initClosed = 1'b0;
          nxt_regs.rstIndN    = 1'b0;
          nxt_regs.fsm        = WDT16_RUN;
          nxt_regs.chipReset  = 1'b0; // no stuck request on a same-cycle overflow
          nxt_regs.busAbort   = 1'b0;
        end
      end

      WDT16_DRAIN: begin
        // wait for the bus cycle to finish
        if (!xbus.active) begin
          nxt_regs.fsm       = WDT16_RESET;
          nxt_regs.chipReset = 1'b1;
          nxt_regs.rstIndN   = 1'b0;
          nxt_regs.seqCnt    = '0;
        end
      end

      WDT16_RESET: begin
        // internal reset sequence, then restart counting
        nxt_regs.seqCnt = regs_ff.seqCnt + 10'h001;
        if (regs_ff.seqCnt == RST_SEQ_CYC - 10'h001) begin
          nxt_regs.fsm        = WDT16_RUN;
          nxt_regs.chipReset  = 1'b0;
          nxt_regs.count      = CNT_RESET;
          nxt_regs.rateSel    = 1'b0;
          nxt_regs.reload     = '0;
          nxt_regs.enabled    = 1'b1;
          nxt_regs.initClosed = 1'b0;
        end
      end

      default: begin
        nxt_regs.fsm = WDT16_RUN;
      end
    endcase

    // register writes, ignored during the reset sequence
    if (bus.wr && regs_ff.fsm != WDT16_RESET) begin
      case (bus.addr)
        OFF_CONTROL: begin
          nxt_regs.reload  = bus.wdata[CTL_RLD_LSB +: RLD_W];
          nxt_regs.rateSel = bus.wdata[CTL_SEL_BIT];
        end
        OFF_INT_STAT: begin
          intClr = bus.wdata[INT_W-1:0];
        end
        OFF_INT_MASK: begin
          nxt_regs.intMask = bus.wdata[INT_W-1:0];
        end
        default: begin
          nxt_regs.intMask = nxt_regs.intMask; // count is read only
        end
      endcase
    end

    // sticky events, a set wins over a clear
    nxt_regs.intStat = (regs_ff.intStat & ~intClr) | intEv;
    nxt_regs.irq     = |(nxt_regs.intStat & nxt_regs.intMask);

    // read data one cycle after the strobe
    if (bus.rd) begin
      case (bus.addr)
        OFF_COUNT: begin
          nxt_regs.readData = regs_ff.count;
        end
        OFF_CONTROL: begin
          nxt_regs.readData = '0;
          nxt_regs.readData[CTL_RLD_LSB +: RLD_W] = regs_ff.reload;
          nxt_regs.readData[CTL_FLAG_BIT] = regs_ff.ovfFlag;
          nxt_regs.readData[CTL_SEL_BIT]  = regs_ff.rateSel;
        end
        OFF_INT_STAT: begin
          nxt_regs.readData = {{(DATA_W-INT_W){1'b0}}, regs_ff.intStat};
        end
        OFF_INT_MASK: begin
          nxt_regs.readData = {{(DATA_W-INT_W){1'b0}}, regs_ff.intMask};
        end
        OFF_STATUS: begin
          nxt_regs.readData = '0;
          nxt_regs.readData[STS_EN_BIT]    = regs_ff.enabled;
          nxt_regs.readData[STS_CLOSE_BIT] = regs_ff.initClosed;
          nxt_regs.readData[STS_RST_BIT]   = regs_ff.fsm != WDT16_RUN;
        end
        default: begin
          nxt_regs.readData = '0;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  // hardware reset: enabled, counting from zero, flag clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regs_ff            <= '0;
      regs_ff.fsm        <= WDT16_RUN;
      regs_ff.enabled    <= 1'b1;
      regs_ff.count      <= CNT_RESET;
      regs_ff.ovfFlag    <= 1'b0;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign regRdData            = regs_ff.readData;
  assign irq                  = regs_ff.irq;
  assign chipResetReq         = regs_ff.chipReset;
  assign xbusAbort            = regs_ff.busAbort;
  assign resetIndicationOut_n = regs_ff.rstIndN;
  assign protectionFaultTrap  = regs_ff.protFault;
endmodule

//--- test/wdt16_properties.sv
// wdt16_properties: port-level checks of the watchdog
// assumes: bound to wdt16_top, one clock clk, rst async high
`timescale 1ns/1ps
module wdt16_properties (
  input wire logic                          clk,
  input wire logic                          rst,
  input wire wdt16_pkg::wdt16_bus_t         bus,
  input wire wdt16_pkg::wdt16_cpu_t         cpuEv,
  input wire wdt16_pkg::wdt16_xbus_t        xbus,
  input wire logic [wdt16_pkg::DATA_W-1:0]  regRdData,
  input wire logic                          chipResetReq,
  input wire logic                          xbusAbort,
  input wire logic                          resetIndicationOut_n,
  input wire logic                          protectionFaultTrap
);
  import wdt16_pkg::*;
  // ----------------------------------------
  // helper: length of the running reset sequence
  // ----------------------------------------
  logic [10:0] seqLen_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      seqLen_ff <= 11'h000;
    else if (chipResetReq)
      seqLen_ff <= seqLen_ff + 11'h001;
    else
      seqLen_ff <= 11'h000;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // reset request with indication held low
  sequence sHeld;
    (chipResetReq && !resetIndicationOut_n) [*8];
  endsequence
  a_seq_len: assert property ($fell(chipResetReq) |-> seqLen_ff == {1'b0, RST_SEQ_CYC})
    else $error("reset sequence length wrong");
  a_seq_start: assert property ($rose(chipResetReq) |-> sHeld)
    else $error("reset request not held with indication");
  a_ind_low: assert property (chipResetReq |-> !resetIndicationOut_n)
    else $error("indication high during reset");
  a_ind_rise: assert property ($rose(resetIndicationOut_n) |-> $past(cpuEv.endInit))
    else $error("indication released without end of init");
  a_rd_idle: assert property (!$past(bus.rd) |-> regRdData == 16'h0000)
    else $error("read data outside read slot");
  a_abort_one: assert property (xbusAbort |=> !xbusAbort)
    else $error("abort longer than one cycle");
  a_abort_rst: assert property (xbusAbort |-> chipResetReq)
    else $error("abort without reset request");
  a_rst_bus: assert property ($rose(chipResetReq) |->
    !$past(xbus.active) || ($past(xbus.usesReady) && !$past(xbus.readyLow)))
    else $error("reset started during a bus cycle to complete");
  a_trap_set: assert property (cpuEv.service && !cpuEv.serviceFormatOk && !chipResetReq
    |=> protectionFaultTrap)
    else $error("no trap on malformed service");
  a_trap_cause: assert property (protectionFaultTrap |->
    $past(cpuEv.service) && !$past(cpuEv.serviceFormatOk))
    else $error("trap without malformed service");
endmodule

bind wdt16_top wdt16_properties wdt16_properties_inst (.clk(clk), .rst(rst), .bus(bus), .cpuEv(cpuEv),
  .xbus(xbus), .regRdData(regRdData), .chipResetReq(chipResetReq), .xbusAbort(xbusAbort),
  .resetIndicationOut_n(resetIndicationOut_n), .protectionFaultTrap(protectionFaultTrap));

//--- test/wdt16_cpu_model.sv
// wdt16_cpu_model: cpu core issuing watchdog instructions
// assumes: strobe called from the bench thread, clk is the cpu clock
`timescale 1ns/1ps
module wdt16_cpu_model (
  input  wire logic             clk,
  output wdt16_pkg::wdt16_cpu_t cpuEv
);
  import wdt16_pkg::*;
  initial cpuEv = '0;
  // ----------------------------------------
  // one strobe: 0 service, 1 disable, 2 end init, 3 soft reset
  // ----------------------------------------
  task automatic strobe(input logic [1:0] k, input logic ok);
    wdt16_cpu_t v;
    v = {k == 2'h0, ok, k == 2'h1, k == 2'h2, k == 2'h3};
    @(posedge clk);
    cpuEv <= v;
    @(posedge clk);
    cpuEv <= '0;
  endtask
endmodule

//--- test/wdt16_top_tb.sv
// wdt16_top_tb: register and instruction sequences against the watchdog
// assumes: wdt16_cpu_model stands for the cpu, 125 MHz clock
`timescale 1ns/1ps
module wdt16_top_tb;
  import wdt16_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        boot = 1'b0;
  wdt16_bus_t  bus = '0;
  wdt16_xbus_t xbus = '0;
  wdt16_cpu_t  cpuEv;
  logic [15:0] rdData, d, e;
  logic        irq, chipResetReq, xbusAbort, resetIndicationOut_n, protectionFaultTrap;
  int          err_total = 0;
  int          n_tests = 0;
  int          c;
  // clock
  always #4 clk = ~clk;
  wdt16_top wdt16_top_inst (.clk(clk), .rst(rst), .bus(bus), .cpuEv(cpuEv), .xbus(xbus),
    .bootstrapPin(boot), .regRdData(rdData), .irq(irq), .chipResetReq(chipResetReq),
    .xbusAbort(xbusAbort), .resetIndicationOut_n(resetIndicationOut_n),
    .protectionFaultTrap(protectionFaultTrap));
  wdt16_cpu_model wdt16_cpu_model_inst (.clk(clk), .cpuEv(cpuEv));
  // ----------------------------------------
  // bus cycles, compare, bounded waits, verdict
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    v = rdData;
  endtask
  task automatic rc(input logic [2:0] a, input logic [15:0] x);
    logic [15:0] v;
    rd(a, v);
    chk(v, x);
  endtask
  task automatic sb(input logic [1:0] k, input logic ok);
    wdt16_cpu_model_inst.strobe(k, ok);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // sel 0: reset request high, 1: irq high, 2: reset request low
  task automatic waitFor(input int sel, input int n);
    logic hit;
    for (int j = 0; j <= n; j++) begin
      @(negedge clk);
      hit = sel == 0 ? chipResetReq === 1'b1 : sel == 1 ? irq === 1'b1 : chipResetReq === 1'b0;
      if (hit)
        return;
    end
    err_total++;
    tally_and_finish();
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rc(OFF_CONTROL, 16'h0000);
    rc(OFF_STATUS, 16'h0001);
    rc(3'h7, 16'h0000);
    wr(OFF_COUNT, 16'hFFFF);
    rd(OFF_COUNT, d);
    chk({15'h0, d < 16'h0040}, 16'h0001);
    repeat (20) @(posedge clk);
    rd(OFF_COUNT, e);
    chk({15'h0, (e - d) inside {[16'h000A:16'h000D]}}, 16'h0001);
    wr(OFF_CONTROL, 16'h0003);
    rc(OFF_CONTROL, 16'h0001);
    rd(OFF_COUNT, d);
    repeat (512) @(posedge clk);
    rd(OFF_COUNT, e);
    chk({15'h0, (e - d) inside {[16'h0003:16'h0005]}}, 16'h0001);
    $display("test 1 done");
    wr(OFF_CONTROL, 16'hFF00);
    sb(2'h0, 1'b1);
    rd(OFF_COUNT, d);
    chk(d & 16'hFFF0, 16'hFF00);
    rc(OFF_STATUS, 16'h0003);
    sb(2'h1, 1'b1);
    rc(OFF_STATUS, 16'h0003);
    rc(OFF_INT_STAT, 16'h0004);
    wr(OFF_INT_MASK, 16'h0002);
    rc(OFF_INT_MASK, 16'h0002);
    sb(2'h0, 1'b0);
    #1 chk({15'h0, protectionFaultTrap}, 16'h0001);
    rc(OFF_INT_STAT, 16'h0006);
    chk({15'h0, irq}, 16'h0001);
    wr(OFF_INT_STAT, 16'h0007);
    rc(OFF_INT_STAT, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    $display("test 2 done");
    for (c = 0; c < 3; c++) begin
      wr(OFF_INT_MASK, 16'h0001);
      wr(OFF_CONTROL, 16'hFF00);
      sb(2'h0, 1'b1);
      xbus <= '{c != 0, c == 2, 1'b0};
      if (c == 1) begin
        waitFor(1, 1200);
        repeat (5) begin
          @(negedge clk);
          chk({15'h0, chipResetReq}, 16'h0000);
        end
        @(posedge clk);
        xbus <= '0;
      end
      waitFor(0, 1200);
      chk({15'h0, xbusAbort}, {15'h0, c == 2});
      chk({15'h0, resetIndicationOut_n}, 16'h0000);
      rc(OFF_STATUS, 16'h0007);
      @(posedge clk);
      xbus <= '0;
      waitFor(2, 600);
      rc(OFF_CONTROL, 16'h0002);
      rd(OFF_COUNT, d);
      chk(d & 16'hFF00, 16'h0000);
      sb(2'h2, 1'b1);
      #1 chk({15'h0, resetIndicationOut_n}, 16'h0001);
      sb(2'h0, 1'b1);
      rc(OFF_CONTROL, 16'h0000);
      wr(OFF_INT_STAT, 16'h0007);
      $display("test 3.%0d done", c);
    end
    sb(2'h3, 1'b1);
    rc(OFF_STATUS, 16'h0001);
    sb(2'h1, 1'b1);
    rc(OFF_STATUS, 16'h0000);
    repeat (10) @(posedge clk);
    rc(OFF_COUNT, 16'h0000);
    $display("test 4 done");
    @(posedge clk);
    boot <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    rc(OFF_STATUS, 16'h0000);
    $display("test 5 done");
    tally_and_finish();
  end
endmodule
